// *** shared/ocd_pkg.sv ***
package ocd_pkg;

	// register offsets on the microprocessor port
	localparam logic [7:0] OCD_AUX_RATE_OFS  = 8'h39;
	localparam logic [7:0] OCD_DIFF_FMT_OFS  = 8'h3A;
	localparam logic [7:0] OCD_LOOP_CTL_OFS  = 8'h3B;

	// values after reset, and the answer to a read of an unmapped place
	localparam logic [7:0] OCD_AUX_RATE_RST  = 8'h08;
	localparam logic [7:0] OCD_DIFF_FMT_RST  = 8'hC6;
	localparam logic [7:0] OCD_LOOP_CTL_RST  = 8'hFB;
	localparam logic [7:0] OCD_UNMAPPED_RD   = 8'h00;

	// field positions
	localparam int OCD_AUX_B_RATE_LSB  = 6;
	localparam int OCD_AUX_A_RATE_LSB  = 4;
	localparam int OCD_DIFF_SEVEN_LSB  = 2;
	localparam int OCD_DIFF_SIX_LSB    = 0;
	localparam int OCD_AUTO_BW_BIT     = 7;
	localparam int OCD_INT_LIMIT_BIT   = 3;

	// width of the reported loop frequency word
	localparam int OCD_FREQ_W = 16;

	// aux output rates in kHz, indexed by rate code
	localparam logic [13:0] OCD_SONET_KHZ_0 = 14'h0608; // 1544
	localparam logic [13:0] OCD_SONET_KHZ_1 = 14'h0C10; // 3088
	localparam logic [13:0] OCD_SONET_KHZ_2 = 14'h1820; // 6176
	localparam logic [13:0] OCD_SONET_KHZ_3 = 14'h3040; // 12352
	localparam logic [13:0] OCD_SDH_KHZ_0   = 14'h0800; // 2048
	localparam logic [13:0] OCD_SDH_KHZ_1   = 14'h1000; // 4096
	localparam logic [13:0] OCD_SDH_KHZ_2   = 14'h2000; // 8192
	localparam logic [13:0] OCD_SDH_KHZ_3   = 14'h3FFF; // 16384 does not fit, top step saturates

	// differential output signalling formats
	typedef enum logic [1:0] {
		OCD_FMT_OFF  = 2'h0,
		OCD_FMT_PECL = 2'h1,
		OCD_FMT_LVDS = 2'h2,
		OCD_FMT_RSVD = 2'h3
	} ocd_fmt_t;

	// microprocessor port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ocd_req_t;

	// loop status from the output dpll
	typedef struct packed {
		logic                  want_acquire;
		logic                  at_freq_limit;
		logic [OCD_FREQ_W-1:0] freq;
	} ocd_loop_t;

	// whole state of the bank
	typedef struct packed {
		logic [7:0]            aux_rate;
		logic [7:0]            diff_fmt;
		logic [7:0]            loop_ctl;
		logic [7:0]            rdata;
		logic [13:0]           aux_a_khz;
		logic [13:0]           aux_b_khz;
		logic                  use_acq_bw;
		logic                  int_hold;
		logic [OCD_FREQ_W-1:0] rep_freq;
	} ocd_state_t;

endpackage

// *** rtl/ocd_cfg_regs.sv ***
// How it works
// (RQ1) aux b rate code picks its rate
// (RQ2) aux a uses same mapping, own family
// (RQ3) family bit one sonet, zero sdh
// (RQ4) code 11 gives family top rate
// (RQ5) diff fields disable or pick pecl/lvds
// (RQ6) auto bit switches bandwidth, else locked
// (RQ7) limit bit freezes integral at frequency limits
// (RQ8) freeze also holds reported loop frequency
module ocd_cfg_regs
	import ocd_pkg::*;
(
	input  wire logic                  ref_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  ce_i,
	input  wire ocd_req_t              req_i,
	input  wire logic                  aux_a_family_select_i,
	input  wire logic                  aux_b_family_select_i,
	input  wire ocd_loop_t             loop_i,
	output logic [7:0]                 rdata_o,
	output logic [13:0]                aux_a_rate_khz_o,
	output logic [13:0]                aux_b_rate_khz_o,
	output logic                       diff_six_enable_o,
	output logic                       diff_six_lvds_o,
	output logic                       diff_seven_enable_o,
	output logic                       diff_seven_lvds_o,
	output logic                       use_acq_bandwidth_o,
	output logic                       integral_hold_o,
	output logic [OCD_FREQ_W-1:0]      reported_loop_frequency_o
);

	ocd_state_t st;      // registered state
	ocd_state_t next_st; // next state

	// code and family to rate in kHz
	function automatic logic [13:0] rate_khz(input logic [1:0] code, input logic sonet);
		logic [13:0] r;
		r = OCD_SDH_KHZ_0;
		case (code)
			2'h0: r = sonet ? OCD_SONET_KHZ_0 : OCD_SDH_KHZ_0; // RQ1 RQ3
			2'h1: r = sonet ? OCD_SONET_KHZ_1 : OCD_SDH_KHZ_1; // RQ1 RQ3
			2'h2: r = sonet ? OCD_SONET_KHZ_2 : OCD_SDH_KHZ_2; // RQ1 RQ3
			2'h3: r = sonet ? OCD_SONET_KHZ_3 : OCD_SDH_KHZ_3; // RQ4
			default: r = OCD_SDH_KHZ_0;
		endcase
		return r;
	endfunction

	// a format field drives its output only for pecl or lvds
	function automatic logic fmt_on(input logic [1:0] f);
		return (f == OCD_FMT_PECL) || (f == OCD_FMT_LVDS);
	endfunction

	// next-state logic: register writes, read data, loop controls
	always_comb begin
		logic [1:0] a_code;
		logic [1:0] b_code;
		logic       freeze;
		a_code  = '0;
		b_code  = '0;
		freeze  = 1'b0;
		next_st = st;
		// writes land first so registered derived outputs follow a cycle later
		if (req_i.wr) begin
			case (req_i.addr)
				OCD_AUX_RATE_OFS: next_st.aux_rate = req_i.wdata;
				OCD_DIFF_FMT_OFS: next_st.diff_fmt = req_i.wdata;
				OCD_LOOP_CTL_OFS: next_st.loop_ctl = req_i.wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
		// reads answer the stored value one cycle later
		if (req_i.rd) begin
			case (req_i.addr)
				OCD_AUX_RATE_OFS: next_st.rdata = st.aux_rate;
				OCD_DIFF_FMT_OFS: next_st.rdata = st.diff_fmt;
				OCD_LOOP_CTL_OFS: next_st.rdata = st.loop_ctl;
				default:          next_st.rdata = OCD_UNMAPPED_RD;
			endcase
		end
		// rates come from the stored codes and the neighbour family bits
		b_code = st.aux_rate[OCD_AUX_B_RATE_LSB +: 2];
		a_code = st.aux_rate[OCD_AUX_A_RATE_LSB +: 2];
		next_st.aux_b_khz = rate_khz(b_code, aux_b_family_select_i); // RQ1
		next_st.aux_a_khz = rate_khz(a_code, aux_a_family_select_i); // RQ2
		// acquisition bandwidth only when automatic choice is allowed
		next_st.use_acq_bw = st.loop_ctl[OCD_AUTO_BW_BIT] & loop_i.want_acquire; // RQ6
		// limiter freezes the integral path at min or max frequency
		freeze = st.loop_ctl[OCD_INT_LIMIT_BIT] & loop_i.at_freq_limit; // RQ7
		next_st.int_hold = freeze;
		// reported value is held while frozen so software sees a steady word
		if (!freeze) begin
			next_st.rep_freq = loop_i.freq; // RQ8
		end
	end

	// state register; ce low freezes everything
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st            <= '0;
			st.aux_rate   <= OCD_AUX_RATE_RST;
			st.diff_fmt   <= OCD_DIFF_FMT_RST;
			st.loop_ctl   <= OCD_LOOP_CTL_RST;
			st.aux_a_khz  <= OCD_SDH_KHZ_0;
			st.aux_b_khz  <= OCD_SDH_KHZ_0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign rdata_o                   = st.rdata;
	assign aux_a_rate_khz_o          = st.aux_a_khz;
	assign aux_b_rate_khz_o          = st.aux_b_khz;
	assign diff_six_enable_o         = fmt_on(st.diff_fmt[OCD_DIFF_SIX_LSB +: 2]); // RQ5
	assign diff_six_lvds_o           = st.diff_fmt[OCD_DIFF_SIX_LSB +: 2] == OCD_FMT_LVDS; // RQ5
	assign diff_seven_enable_o       = fmt_on(st.diff_fmt[OCD_DIFF_SEVEN_LSB +: 2]); // RQ5
	assign diff_seven_lvds_o         = st.diff_fmt[OCD_DIFF_SEVEN_LSB +: 2] == OCD_FMT_LVDS; // RQ5
	assign use_acq_bandwidth_o       = st.use_acq_bw;
	assign integral_hold_o           = st.int_hold;
	assign reported_loop_frequency_o = st.rep_freq;

	// a sonet step-one request, one cycle of ce
	sequence s_b_code1_sonet;
		ce_i && st.aux_rate[7:6] == 2'h1 && aux_b_family_select_i;
	endsequence

	a_b_rate_sonet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ1
		s_b_code1_sonet |=> aux_b_rate_khz_o == 14'h0C10) // RQ1
		else $error("aux b rate wrong for sonet code 01");

	a_a_rate_sdh: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ2
		ce_i && st.aux_rate[5:4] == 2'h2 && !aux_a_family_select_i
		|=> aux_a_rate_khz_o == 14'h2000) // RQ2
		else $error("aux a rate wrong for sdh code 10");

	a_family_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ3
		ce_i && st.aux_rate[7:6] == 2'h0 && !aux_b_family_select_i
		|=> aux_b_rate_khz_o == 14'h0800) // RQ3
		else $error("sdh family not applied");

	a_top_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ4
		ce_i && st.aux_rate[5:4] == 2'h3 && aux_a_family_select_i
		|=> aux_a_rate_khz_o == 14'h3040) // RQ4
		else $error("code 11 not at sonet top rate");

	a_diff_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
		st.diff_fmt[3:2] == 2'h0 |-> !diff_seven_enable_o) // RQ5
		else $error("disabled differential output enabled");

	a_locked_bw: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
		ce_i && !st.loop_ctl[7] |=> !use_acq_bandwidth_o) // RQ6
		else $error("acquisition bandwidth with auto off");

	a_auto_bw: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
		ce_i && st.loop_ctl[7] && loop_i.want_acquire |=> use_acq_bandwidth_o) // RQ6
		else $error("auto bandwidth ignored");

	a_int_freeze: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ7
		ce_i && st.loop_ctl[3] && loop_i.at_freq_limit |=> integral_hold_o) // RQ7
		else $error("integral not frozen at limit");

	a_no_freeze: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ7
		ce_i && !st.loop_ctl[3] |=> !integral_hold_o) // RQ7
		else $error("integral frozen with limiter off");

	a_freq_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
		ce_i && st.loop_ctl[3] && loop_i.at_freq_limit
		|=> $stable(reported_loop_frequency_o)) // RQ8
		else $error("reported frequency moved while frozen");

	a_freq_track: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
		ce_i && !st.loop_ctl[3] |=> reported_loop_frequency_o == $past(loop_i.freq)) // RQ8
		else $error("reported frequency not tracking");

	// six at its lvds code: driven, lvds signalling
	a_six_lvds_fmt: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
		st.diff_fmt[OCD_DIFF_SIX_LSB +: 2] == OCD_FMT_LVDS
		|-> diff_six_enable_o && diff_six_lvds_o)
		else $error("diff six not in lvds format");

	// seven at its pecl code: driven, pecl signalling
	a_seven_pecl_fmt: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
		st.diff_fmt[OCD_DIFF_SEVEN_LSB +: 2] == OCD_FMT_PECL
		|-> diff_seven_enable_o && !diff_seven_lvds_o)
		else $error("diff seven not in pecl format");

	// reserved code keeps the pins quiet rather than guess a format
	a_six_reserved: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
		st.diff_fmt[OCD_DIFF_SIX_LSB +: 2] == OCD_FMT_RSVD |-> !diff_six_enable_o)
		else $error("diff six driven on reserved code");

	// top code on b under sonet lands on the highest sonet step
	a_b_top_sonet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ4
		ce_i && st.aux_rate[OCD_AUX_B_RATE_LSB +: 2] == 2'h3 && aux_b_family_select_i
		|=> aux_b_rate_khz_o == OCD_SONET_KHZ_3)
		else $error("aux b code 11 not at sonet top rate");

	// a family bit set gives the sonet base rate on code 00
	a_a_base_sonet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ3
		ce_i && st.aux_rate[OCD_AUX_A_RATE_LSB +: 2] == 2'h0 && aux_a_family_select_i
		|=> aux_a_rate_khz_o == OCD_SONET_KHZ_0)
		else $error("aux a sonet base rate wrong");

	// a taken write that sets the automatic bandwidth bit
	sequence s_auto_bw_write;
		ce_i && req_i.wr && req_i.addr == OCD_LOOP_CTL_OFS && req_i.wdata[OCD_AUTO_BW_BIT];
	endsequence

	// the loop asks for acquisition on an enabled edge
	sequence s_acquire_ask;
		ce_i && loop_i.want_acquire;
	endsequence

	// write lands, then the next request is honoured a cycle later
	a_auto_after_wr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
		s_auto_bw_write ##1 s_acquire_ask |=> use_acq_bandwidth_o)
		else $error("auto bandwidth write not applied");

	// one enabled edge with the limiter armed and the loop at a limit
	sequence s_frozen_edge;
		ce_i && st.loop_ctl[OCD_INT_LIMIT_BIT] && loop_i.at_freq_limit;
	endsequence

	// two frozen edges in a row: integral held, word unchanged over both
	a_freeze_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
		s_frozen_edge ##1 s_frozen_edge
		|=> integral_hold_o && reported_loop_frequency_o == $past(reported_loop_frequency_o, 2))
		else $error("reported frequency drifted during freeze");

endmodule // ocd_cfg_regs

// *** tb/test_ocd_cfg_regs.sv ***
module test_ocd_cfg_regs
	import ocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  clk;       // bench clock, 100 MHz
	logic                  rst;       // active high reset
	logic                  ce;        // clock enable
	ocd_req_t              req;       // register port request
	logic                  fam_a;     // aux a family, 1 sonet
	logic                  fam_b;     // aux b family, 1 sonet
	ocd_loop_t             loop;      // dpll status stand-in
	logic [7:0]            rdata;     // read answer
	logic [13:0]           khz_a;     // aux a rate
	logic [13:0]           khz_b;     // aux b rate
	logic                  en6;       // diff six on
	logic                  lv6;       // diff six lvds
	logic                  en7;       // diff seven on
	logic                  lv7;       // diff seven lvds
	logic                  acq;       // acquisition bandwidth in use
	logic                  hold;      // integral path frozen
	logic [OCD_FREQ_W-1:0] freq;      // reported loop frequency
	int                    failures;
	int                    samples_checked;
	// expected rate steps, sonet row then sdh row
	logic [13:0] son_k [4] = '{OCD_SONET_KHZ_0, OCD_SONET_KHZ_1, OCD_SONET_KHZ_2, OCD_SONET_KHZ_3};
	logic [13:0] sdh_k [4] = '{OCD_SDH_KHZ_0, OCD_SDH_KHZ_1, OCD_SDH_KHZ_2, OCD_SDH_KHZ_3};

	ocd_cfg_regs ocd_cfg_regs_inst (
		.ref_clk_i                 (clk),
		.sys_rst_i                 (rst),
		.ce_i                      (ce),
		.req_i                     (req),
		.aux_a_family_select_i     (fam_a),
		.aux_b_family_select_i     (fam_b),
		.loop_i                    (loop),
		.rdata_o                   (rdata),
		.aux_a_rate_khz_o          (khz_a),
		.aux_b_rate_khz_o          (khz_b),
		.diff_six_enable_o         (en6),
		.diff_six_lvds_o           (lv6),
		.diff_seven_enable_o       (en7),
		.diff_seven_lvds_o         (lv7),
		.use_acq_bandwidth_o       (acq),
		.integral_hold_o           (hold),
		.reported_loop_frequency_o (freq)
	);

	// free running clock
	always #5 clk = ~clk;

	// case equality so an unknown never passes
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one write pulse, then wait until derived outputs have landed
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// one read pulse; answer is registered one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk("read data", 16'(rdata), 16'(exp));
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		clk = 1'b0; rst = 1'b1; ce = 1'b1; req = '0; fam_a = 1'b0; fam_b = 1'b0;
		loop = '0; failures = 0; samples_checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1 chk("rate a rst", 16'(khz_a), 16'(OCD_SDH_KHZ_0));
		chk("rate b rst", 16'(khz_b), 16'(OCD_SDH_KHZ_0));
		chk("diff rst", 16'({en6, lv6, en7, lv7}), 16'h000E);
		rd(OCD_AUX_RATE_OFS, 8'h08);
		rd(OCD_DIFF_FMT_OFS, 8'hC6);
		rd(OCD_LOOP_CTL_OFS, 8'hFB);
		// unmapped place: write dropped, read gives zero
		wr(8'h40, 8'hAA);
		rd(8'h40, OCD_UNMAPPED_RD);
		// every rate code under both families, a and b opposite
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge clk);
				fam_a <= f[0];
				fam_b <= ~f[0];
				wr(OCD_AUX_RATE_OFS, {2'(3 - c), 2'(c), 4'h0});
				chk("rate a", 16'(khz_a), 16'(f ? son_k[c] : sdh_k[c]));
				chk("rate b", 16'(khz_b), 16'(f ? sdh_k[3-c] : son_k[3-c]));
			end
		end
		// every format code, six gets the mirror code of seven
		for (int c = 0; c < 4; c++) begin
			wr(OCD_DIFF_FMT_OFS, {4'h0, 2'(c), 2'(3 - c)});
			chk("diff seven", 16'({en7, lv7}), 16'({c == 1 || c == 2, c == 2}));
			chk("diff six", 16'({en6, lv6}), 16'({c == 1 || c == 2, c == 1}));
		end
		// bandwidth choice follows the dpll only in auto mode
		@(posedge clk);
		loop.want_acquire <= 1'b1;
		wr(OCD_LOOP_CTL_OFS, 8'h80);
		chk("acq auto", 16'(acq), 16'h0001);
		wr(OCD_LOOP_CTL_OFS, 8'h00);
		chk("acq locked", 16'(acq), 16'h0000);
		// limiter: freeze only at a frequency limit, reported word held
		@(posedge clk);
		loop.freq <= 16'h1234;
		wr(OCD_LOOP_CTL_OFS, 8'h08);
		chk("hold off", 16'(hold), 16'h0000);
		chk("freq live", freq, 16'h1234);
		@(posedge clk);
		loop.at_freq_limit <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("hold on", 16'(hold), 16'h0001);
		@(posedge clk);
		loop.freq <= 16'h5678;
		repeat (2) @(posedge clk);
		#1 chk("freq held", freq, 16'h1234);
		wr(OCD_LOOP_CTL_OFS, 8'h00);
		chk("hold clear", 16'(hold), 16'h0000);
		chk("freq free", freq, 16'h5678);
		// clock enable low: the write is ignored
		@(posedge clk);
		ce <= 1'b0;
		wr(OCD_LOOP_CTL_OFS, 8'h55);
		@(posedge clk);
		ce <= 1'b1;
		rd(OCD_LOOP_CTL_OFS, 8'h00);
		// mid-run reset: registers return to their defaults
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk("diff rst again", 16'({en6, lv6, en7, lv7}), 16'h000E);
		rd(OCD_LOOP_CTL_OFS, OCD_LOOP_CTL_RST);
		report_and_stop();
	end

	// watchdog, far beyond the roughly 120 cycles the tests need
	initial begin
		#100us;
		failures++;
		report_and_stop();
	end
endmodule // test_ocd_cfg_regs
